// File: verilog/idp_page.sv
`timescale 1ns/1ps
// Functional notes
// - word 0: bit 6 set, bits 15 and 7 and all others clear
// - words 10-19 hold 20-character serial number, right-justified
// - words 23-26 hold 8-character firmware revision, left-justified
// - words 27-46 hold 40-character model name, 36 from the store, the last 4 always spaces
// - word 49: IORDY, LBA, DMA supported; bits 13 and 10 clear
// - word 51 upper byte 02h reports PIO mode 2
// - word 53 reads 0007h marking words 54-58, 64-70, 88 valid
// - word 59: bit 8 multiple enable, low byte current count 2/4/8/16
// - word 63: upper byte current multiword DMA, low bits 0-2 set
// - word 64 reads 0003h: PIO modes 3 and 4 supported
// - word 80 bits 1-4 set, others zero
// - word 82 reads 346Bh for supported command sets
// - word 83 sets only bit 3 among bits 4-0
// - word 85: look-ahead, write cache, security, SMART enabled
// - word 86 sets only bit 3
// - word 88: current ultra DMA in bits 12-8, bits 4-0 set
// - word 93 bit 13 shows 80-conductor cable sensed
// - opcode EEh returns the same page as identify, DMA allowed
// - set features 02h/82h turn write cache on/off, shown in word 85
module idp_page (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import idp_pkg::*;

   typedef enum {IDP_IDLE, IDP_LOAD, IDP_SEND} idp_state_e;

   typedef struct packed {
      idp_state_e st;
      logic wc_en;
      logic mult_en;
      logic [7:0] mult_cnt;
      logic [7:0] mdma_cur;
      logic [4:0] udma_cur;
      logic cbl80;
      logic dma_req;
      logic dma_mode;
      logic abort;
      logic [15:0] word;
      logic word_vld;
      logic [31:0] rdata;
   } idp_state_s;

   idp_state_s s_q, s_d;

   logic acc, wr, rd;
   logic str_we;
   logic [5:0] str_wa;
   logic [7:0] str_wd;
   logic [4:0] str_ra;
   logic [15:0] str_rd;
   logic ctr_clr, ctr_step, ctr_last;
   logic [7:0] widx;
   logic [7:0] nidx;
   logic [15:0] page_w;
   logic [7:0] cmd_op, cmd_ft;
   logic cnt_ok;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign pready = 1'b1;
   assign cmd_op = pwdata[15:8];
   assign cmd_ft = pwdata[7:0];

   // string store write: byte index in [13:8], character in [7:0]
   assign str_we = wr && (paddr == IDP_OFF_STR);
   assign str_wa = pwdata[13:8];
   assign str_wd = pwdata[7:0];

   idp_str_mem #(.DEPTH(64)) u_str (
      .ref_clk(ref_clk),
      .wr_en(str_we),
      .wr_addr(str_wa),
      .wr_data(str_wd),
      .rd_addr(str_ra),
      .rd_data(str_rd)
   );

   idp_word_ctr #(.WIDTH(8)) u_ctr (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(ctr_clr),
      .step(ctr_step),
      .count(widx),
      .last(ctr_last)
   );

   // word index presented to the string store: the next one once a word is taken
   assign ctr_clr = (s_q.st == IDP_IDLE);
   assign ctr_step = (s_q.st == IDP_SEND) && rd && (paddr == IDP_OFF_DATA) && !ctr_last;
   // the string store is addressed one word ahead so its registered data is
   // ready for the single load cycle that follows a data read
   assign nidx = ctr_step ? 8'(widx + 8'd1) : widx;

   // string layout in the store: serial 0-19, firmware 20-27, model 28-63
   always_comb begin
      str_ra = 5'h00;
      if (nidx >= 8'd10 && nidx <= 8'd19) begin
         str_ra = 5'(nidx - 8'd10);
      end else if (nidx >= 8'd23 && nidx <= 8'd26) begin
         str_ra = 5'(nidx - 8'd13);
      end else if (nidx >= 8'd27 && nidx <= 8'd44) begin
         str_ra = 5'(nidx - 8'd13);
      end
   end

   // page content for the current word, whose string data was addressed one cycle earlier
   function automatic logic [15:0] page_word(input logic [7:0] idx, input idp_state_s s,
                                             input logic [15:0] sw);
      logic [15:0] w;
      w = 16'h0000;
      case (idx)
         8'd0: w = IDP_W0;
         8'd49: w = IDP_W49;
         8'd51: w = IDP_W51;
         8'd53: w = IDP_W53;
         8'd59: w = {7'h00, s.mult_en, s.mult_cnt};
         8'd63: w = {s.mdma_cur, IDP_W63_SUP};
         8'd64: w = IDP_W64;
         8'd80: w = IDP_W80;
         8'd82: w = IDP_W82;
         8'd83: w = IDP_W83;
         8'd85: begin
            w = IDP_W85_BASE;
            w[IDP_W85_WC] = s.wc_en;
         end
         8'd86: w = IDP_W86;
         8'd88: w = {3'h0, s.udma_cur, 3'h0, IDP_W88_SUP};
         8'd93: begin
            w[IDP_W93_CBL] = s.cbl80;
         end
         8'd45, 8'd46: w = {IDP_SPACE, IDP_SPACE};
         default: begin
            if ((idx >= 8'd10 && idx <= 8'd19) || (idx >= 8'd23 && idx <= 8'd44)) begin
               w = sw;
            end
         end
      endcase
      return w;
   endfunction

   assign page_w = page_word(widx, s_q, str_rd);

   function automatic logic count_ok(input logic [7:0] c);
      return (c == 8'd2) || (c == 8'd4) || (c == 8'd8) || (c == 8'd16);
   endfunction
   assign cnt_ok = count_ok(pwdata[7:0]);

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         IDP_IDLE: begin
            s_d.word_vld = 1'b0;
         end
         IDP_LOAD: begin
            // one cycle for the string store read to settle
            s_d.st = IDP_SEND;
            s_d.word = page_w;
            s_d.word_vld = 1'b1;
         end
         IDP_SEND: begin
            if (rd && (paddr == IDP_OFF_DATA)) begin
               if (ctr_last) begin
                  s_d.st = IDP_IDLE;
                  s_d.word_vld = 1'b0;
                  s_d.dma_req = 1'b0;
               end else begin
                  s_d.st = IDP_LOAD;
                  s_d.word_vld = 1'b0;
               end
            end
         end
         default: s_d.st = IDP_IDLE;
      endcase
      if (wr && (paddr == IDP_OFF_CMD) && (s_q.st == IDP_IDLE)) begin
         s_d.abort = 1'b0;
         case (cmd_op)
            IDP_OP_IDENT: begin
               s_d.st = IDP_LOAD;
               s_d.dma_req = 1'b0;
            end
            IDP_OP_IDENT_DMA: begin
               s_d.st = IDP_LOAD;
               s_d.dma_req = s_q.dma_mode;
            end
            IDP_OP_SETF: begin
               if (cmd_ft == IDP_FEAT_WC_ON) begin
                  s_d.wc_en = 1'b1;
               end else if (cmd_ft == IDP_FEAT_WC_OFF) begin
                  s_d.wc_en = 1'b0;
               end else begin
                  s_d.abort = 1'b1;
               end
            end
            default: s_d.abort = 1'b1;
         endcase
      end
      if (wr && (paddr == IDP_OFF_CTRL)) begin
         s_d.mult_en = pwdata[IDP_CTRL_MULT_EN];
         s_d.cbl80 = pwdata[IDP_CTRL_CBL80];
         s_d.dma_mode = pwdata[IDP_CTRL_DMA];
         if (cnt_ok) begin
            s_d.mult_cnt = pwdata[7:0];
         end
      end
      if (wr && (paddr == IDP_OFF_MODE)) begin
         if (pwdata[7:0] <= 8'd2) begin
            s_d.mdma_cur = 8'(1) << pwdata[1:0];
         end
         if (pwdata[15:8] <= 8'd4) begin
            s_d.udma_cur = 5'(5'd1 << pwdata[10:8]);
         end
      end
      // read data registered in the access cycle
      s_d.rdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            IDP_OFF_CTRL: s_d.rdata = {21'h0, s_q.dma_mode, s_q.cbl80, s_q.mult_en,
                                      s_q.mult_cnt};
            IDP_OFF_STAT: s_d.rdata = {20'h0, s_q.dma_req, s_q.abort, s_q.wc_en,
                                      s_q.word_vld, widx};
            IDP_OFF_DATA: s_d.rdata = {16'h0, s_q.word};
            IDP_OFF_MODE: s_d.rdata = {16'h0, 3'h0, s_q.udma_cur, s_q.mdma_cur};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '{st: IDP_IDLE, wc_en: 1'b1, mult_en: 1'b0, mult_cnt: IDP_RST_MULT,
                  mdma_cur: IDP_RST_MDMA, udma_cur: IDP_RST_UDMA, cbl80: 1'b0,
                  dma_req: 1'b0, dma_mode: 1'b0, abort: 1'b0, word: 16'h0000,
                  word_vld: 1'b0, rdata: 32'h0000_0000};
      end else begin
         s_q <= s_d;
      end
   end

   // combinational read path keeps a zero-wait apb answer
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         prdata = s_d.rdata;
      end
   end

   assign pslverr = acc && !(paddr == IDP_OFF_CTRL || paddr == IDP_OFF_CMD ||
                    paddr == IDP_OFF_STAT || paddr == IDP_OFF_DATA ||
                    paddr == IDP_OFF_MODE || paddr == IDP_OFF_STR);

   a_wc_on: assert property (@(posedge ref_clk) disable iff (rst)
      wr && paddr == IDP_OFF_CMD && s_q.st == IDP_IDLE && cmd_op == IDP_OP_SETF &&
      cmd_ft == IDP_FEAT_WC_ON |=> s_q.wc_en) else $error("write cache not enabled");
   a_wc_off: assert property (@(posedge ref_clk) disable iff (rst)
      wr && paddr == IDP_OFF_CMD && s_q.st == IDP_IDLE && cmd_op == IDP_OP_SETF &&
      cmd_ft == IDP_FEAT_WC_OFF |=> !s_q.wc_en) else $error("write cache not off");
   a_word0_val: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd0 |=> s_q.word == 16'h0040)
      else $error("word 0 wrong");
   a_word49_val: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd49 |=> s_q.word == 16'h0B00)
      else $error("word 49 wrong");
   a_word82_val: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd82 |=> s_q.word == 16'h346B)
      else $error("word 82 wrong");
   a_word85_wc: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd85 |=> s_q.word == {9'h0, 1'b1, s_q.wc_en, 5'h03})
      else $error("word 85 wrong");
   a_word88_sup: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd88 |=> s_q.word[7:0] == 8'h1F && s_q.word[15:13] == 3'h0)
      else $error("word 88 wrong");
   a_word93_cbl: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_LOAD && widx == 8'd93 |=> s_q.word == {2'h0, s_q.cbl80, 13'h0})
      else $error("word 93 wrong");
   a_page_end: assert property (@(posedge ref_clk) disable iff (rst)
      s_q.st == IDP_SEND && ctr_last && rd && paddr == IDP_OFF_DATA |=> s_q.st == IDP_IDLE)
      else $error("page did not end after word 255");
   a_dma_ident: assert property (@(posedge ref_clk) disable iff (rst)
      wr && paddr == IDP_OFF_CMD && s_q.st == IDP_IDLE && cmd_op == IDP_OP_IDENT_DMA
      |=> s_q.st == IDP_LOAD && widx == 8'd0) else $error("dma identify not started");
endmodule

// File: verilog/idp_pkg.sv
package idp_pkg;
   // apb register map
   localparam logic [7:0] IDP_OFF_CTRL = 8'h00;
   localparam logic [7:0] IDP_OFF_CMD = 8'h04;
   localparam logic [7:0] IDP_OFF_STAT = 8'h08;
   localparam logic [7:0] IDP_OFF_DATA = 8'h0C;
   localparam logic [7:0] IDP_OFF_MODE = 8'h10;
   localparam logic [7:0] IDP_OFF_STR = 8'h14;
   // ctrl fields
   localparam int IDP_CTRL_MULT_EN = 8;
   localparam int IDP_CTRL_CBL80 = 9;
   localparam int IDP_CTRL_DMA = 10;
   // cmd fields: [15:8] opcode, [7:0] feature value
   localparam logic [7:0] IDP_OP_IDENT = 8'hEC;
   localparam logic [7:0] IDP_OP_IDENT_DMA = 8'hEE;
   localparam logic [7:0] IDP_OP_SETF = 8'hEF;
   localparam logic [7:0] IDP_FEAT_WC_ON = 8'h02;
   localparam logic [7:0] IDP_FEAT_WC_OFF = 8'h82;
   // reset values
   localparam logic [7:0] IDP_RST_MULT = 8'h10;
   localparam logic [7:0] IDP_RST_MDMA = 8'h04;
   localparam logic [4:0] IDP_RST_UDMA = 5'h10;
   // fixed page words
   localparam logic [15:0] IDP_W0 = 16'h0040;
   localparam logic [15:0] IDP_W49 = 16'h0B00;
   localparam logic [15:0] IDP_W51 = 16'h0200;
   localparam logic [15:0] IDP_W53 = 16'h0007;
   localparam logic [7:0] IDP_W63_SUP = 8'h07;
   localparam logic [15:0] IDP_W64 = 16'h0003;
   localparam logic [15:0] IDP_W80 = 16'h001E;
   localparam logic [15:0] IDP_W82 = 16'h346B;
   localparam logic [15:0] IDP_W83 = 16'h0008;
   localparam logic [15:0] IDP_W85_BASE = 16'h0043;
   localparam int IDP_W85_WC = 5;
   localparam logic [15:0] IDP_W86 = 16'h0008;
   localparam logic [4:0] IDP_W88_SUP = 5'h1F;
   localparam int IDP_W93_CBL = 13;
   localparam logic [7:0] IDP_SPACE = 8'h20;
   localparam int IDP_PAGE_WORDS = 256;
endpackage

// File: verilog/idp_str_mem.sv
`timescale 1ns/1ps
// string store: 64 bytes of characters, registered read of one word
module idp_str_mem #(
   parameter int DEPTH = 64
) (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [5:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [4:0] rd_addr,
   output logic [15:0] rd_data
);
   // the address widths above are fixed to a 64-byte store
   if (DEPTH != 64) begin : g_depth_chk
      $error("idp_str_mem depth must be 64");
   end
   logic [7:0] mem [DEPTH];
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      // first character in the upper byte, as ata strings are sent
      rd_data <= {mem[{rd_addr, 1'b0}], mem[{rd_addr, 1'b1}]};
   end
endmodule

// File: verilog/idp_word_ctr.sv
`timescale 1ns/1ps
module idp_word_ctr #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic step,
   output logic [WIDTH-1:0] count,
   output logic last
);
   if (WIDTH < 1) begin : g_width_chk
      $error("idp_word_ctr width too small");
   end
   always_ff @(posedge ref_clk) begin
      if (rst || clr) begin
         count <= '0;
      end else if (step) begin
         count <= count + 1'b1;
      end
   end
   assign last = &count;
endmodule

// File: tb/idp_host.sv
`timescale 1ns/1ps
// host side: apb master that waits for pready with no assumed latency
module idp_host (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   import idp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic e;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [7:0] sb [64];
   string sn = "SN0042";
   string fw = "FW1";
   string mdl = "MDL9";
   logic [7:0] mult_cnt = 8'h10;
   logic mult_en = 1'b0;
   logic cbl = 1'b0;
   logic wc = 1'b1;
   logic [7:0] mdma_oh = 8'h04;
   logic [4:0] udma_oh = 5'h10;
   always #2.5 ref_clk = ~ref_clk;
   idp_page u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   idp_host u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk_w(input logic [15:0] g, input logic [15:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk_b(input logic g, input logic x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic re;
      u_host.xfer(1'b1, a, d, r, re);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic re);
      u_host.xfer(1'b0, a, 32'h0, r, re);
   endtask
   function automatic logic [15:0] exp_word(int k);
      if (k >= 10 && k <= 19) return {sb[2*k-20], sb[2*k-19]};
      if (k >= 23 && k <= 44) return {sb[2*k-26], sb[2*k-25]};
      case (k)
         0: return 16'h0040;
         45, 46: return 16'h2020;
         49: return 16'h0B00;
         51: return 16'h0200;
         53: return 16'h0007;
         59: return {7'h00, mult_en, mult_cnt};
         63: return {mdma_oh, 8'h07};
         64: return 16'h0003;
         80: return 16'h001E;
         82: return 16'h346B;
         83: return 16'h0008;
         85: return 16'h0043 | {10'h000, wc, 5'h00};
         86: return 16'h0008;
         88: return {3'h0, udma_oh, 8'h1F};
         93: return {2'b00, cbl, 13'h0000};
         default: return 16'h0000;
      endcase
   endfunction
   // issue an identify opcode, then pull the page word by word
   task automatic read_page(input logic [7:0] op, input logic dreq);
      logic [31:0] s;
      logic se;
      wr(IDP_OFF_CMD, {16'h0000, op, 8'h00});
      rd(IDP_OFF_STAT, s, se);
      chk_b(s[11], dreq);
      for (int k = 0; k < 256; k++) begin
         s = 32'h0;
         while (s[8] !== 1'b1) rd(IDP_OFF_STAT, s, se);
         chk_w({8'h00, s[7:0]}, 16'(k));
         rd(IDP_OFF_DATA, s, se);
         if (k < 47) chk_w(s[15:0], exp_word(k));
         else if (k < 65) chk_w(s[15:0], exp_word(k));
         else chk_w(s[15:0], exp_word(k));
      end
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rd(IDP_OFF_STAT, q, e);
      chk_b(q[9], 1'b1);
      rd(IDP_OFF_MODE, q, e);
      chk_w({3'h0, q[12:0]}, 16'h1004);
      rd(8'hFC, q, e);
      chk_b(e, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 64; i++) sb[i] = 8'h20;
      for (int j = 0; j < 6; j++) sb[14+j] = sn[j];
      for (int j = 0; j < 3; j++) sb[20+j] = fw[j];
      for (int j = 0; j < 4; j++) sb[28+j] = mdl[j];
      for (int i = 0; i < 64; i++) wr(IDP_OFF_STR, {18'h0, 6'(i), sb[i]});
      mult_cnt = 8'h08;
      mult_en = 1'b1;
      cbl = 1'b1;
      wr(IDP_OFF_CTRL, {21'h0, 1'b0, cbl, mult_en, mult_cnt});
      wr(IDP_OFF_MODE, 32'h0000_0201);
      mdma_oh = 8'h02;
      udma_oh = 5'h04;
      read_page(IDP_OP_IDENT, 1'b0);
      $display("test identify done");
      wr(IDP_OFF_CMD, {16'h0000, IDP_OP_SETF, IDP_FEAT_WC_OFF});
      wc = 1'b0;
      rd(IDP_OFF_STAT, q, e);
      chk_b(q[9], 1'b0);
      mult_cnt = 8'h04;
      mult_en = 1'b0;
      cbl = 1'b0;
      wr(IDP_OFF_CTRL, {21'h0, 1'b1, cbl, mult_en, mult_cnt});
      read_page(IDP_OP_IDENT_DMA, 1'b1);
      $display("test identify dma done");
      wr(IDP_OFF_CMD, {16'h0000, IDP_OP_SETF, 8'h99});
      rd(IDP_OFF_STAT, q, e);
      chk_b(q[10], 1'b1);
      wr(IDP_OFF_CMD, {16'h0000, IDP_OP_SETF, IDP_FEAT_WC_ON});
      rd(IDP_OFF_STAT, q, e);
      chk_b(q[9], 1'b1);
      wr(IDP_OFF_CTRL, {21'h0, 1'b0, 1'b0, 1'b0, 8'h05});
      rd(IDP_OFF_CTRL, q, e);
      chk_w(q[15:0], 16'h0004);
      $display("test set features done");
      conclude();
   end
endmodule
